// ===== domo_analog_ch.sv
`timescale 1ns/1ps
module domo_analog_ch
    import domo_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Settings
    input wire logic [7:0] gain,
    input wire logic signed [8:0] bias,
    input wire logic signed [11:0] level_in,
    // Result, 0x3ff per 10 V
    output logic signed [11:0] level_out
);
    logic signed [21:0] scaled;
    logic signed [21:0] sum;
    logic signed [11:0] next_level_out;

    // Gain first, then bias, then clamp to +/-10 V
    always_comb
    begin
        scaled = (22'(level_in) * $signed({14'h0000, gain})) / 22'sd100;
        sum = scaled + 22'(bias) * 22'(LEVEL_PER_TENTH);
        if (sum > 22'(LEVEL_FULL))
            next_level_out = LEVEL_FULL;
        else if (sum < -22'(LEVEL_FULL))
            next_level_out = -LEVEL_FULL;
        else
            next_level_out = sum[11:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level_out <= 12'sh000;
        else
            level_out <= next_level_out;
    end
endmodule

// ===== domo_monitor.sv
`timescale 1ns/1ps
module domo_monitor
    import domo_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Drive core, same clock
    input wire domo_status_t status,
    input wire domo_faults_t faults,
    input wire logic [11:0] mon_levels [0:31],
    input wire logic [31:0] out_freq_step,
    input wire logic link_ok,
    // Outputs
    output logic signed [11:0] analog_ch1,
    output logic signed [11:0] analog_ch2,
    output logic [1:0] relay_out,
    output logic [7:0] term_out,
    output logic pulse_out,
    output logic comm_loss_fault,
    output domo_stop_t comm_stop_action,
    output logic comm_alarm,
    output logic irq
);
    // Configuration registers
    logic [5:0] analog_ch1_source_select, analog_ch2_source_select;
    logic [7:0] analog_ch1_gain, analog_ch2_gain;
    logic signed [8:0] analog_ch1_bias, analog_ch2_bias;
    logic [5:0] relay_ch1_source, relay_ch2_source;
    logic eight_line_output_mode;
    logic [2:0] pulse_monitor_multiplier;
    domo_stop_t comm_loss_stop_method;
    logic [IRQ_W-1:0] irq_status, irq_mask;
    // Bus address phase capture
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] next_wr_addr;
    logic next_wr_pend;
    logic [31:0] next_hrdata;
    logic [7:0] eff_addr;
    logic take;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign take = hsel && hready && htrans[1];

    // Read data registered at address phase; writes land in data phase
    always_comb
    begin
        next_wr_pend = take && hwrite;
        next_wr_addr = haddr[7:0];
        eff_addr = haddr[7:0];
        next_hrdata = 32'h0000_0000;
        if (take && !hwrite)
        begin
            unique case (eff_addr)
                ADDR_ANALOG_CFG: next_hrdata = {analog_ch2_gain, analog_ch1_gain,
                    2'b00, analog_ch2_source_select, 2'b00, analog_ch1_source_select};
                ADDR_ANALOG_BIAS: next_hrdata = {7'h00, analog_ch2_bias,
                    7'h00, analog_ch1_bias};
                ADDR_RELAY_CFG: next_hrdata = {18'h00000, relay_ch2_source,
                    2'b00, relay_ch1_source};
                ADDR_MODE_CFG: next_hrdata = {24'h000000, comm_loss_stop_method,
                    pulse_monitor_multiplier, 2'b00, eight_line_output_mode};
                ADDR_IRQ_STATUS: next_hrdata = {29'h0, irq_status};
                ADDR_IRQ_MASK: next_hrdata = {29'h0, irq_mask};
                ADDR_LEVELS: next_hrdata = {4'h0, analog_ch2, 4'h0, analog_ch1};
                ADDR_OUTPUTS: next_hrdata = {20'h00000, comm_loss_fault,
                    pulse_out, relay_out, term_out};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
        end
    end

    // Config writes; gain and bias clamp to their legal range
    logic [IRQ_W-1:0] irq_events;
    logic [IRQ_W-1:0] next_irq_status;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            analog_ch1_source_select <= SRC1_RESET;
            analog_ch2_source_select <= SRC2_RESET;
            analog_ch1_gain <= GAIN1_RESET;
            analog_ch2_gain <= GAIN2_RESET;
            analog_ch1_bias <= BIAS_RESET;
            analog_ch2_bias <= BIAS_RESET;
            relay_ch1_source <= RLY1_RESET;
            relay_ch2_source <= RLY2_RESET;
            eight_line_output_mode <= 1'b0;
            pulse_monitor_multiplier <= PULSE_SEL_RESET;
            comm_loss_stop_method <= STOP_COAST;
            irq_mask <= '0;
        end
        else if (wr_pend)
        begin
            unique case (wr_addr)
                ADDR_ANALOG_CFG:
                begin
                    analog_ch1_source_select <= hwdata[5:0];
                    analog_ch2_source_select <= hwdata[13:8];
                    analog_ch1_gain <= (hwdata[23:16] > GAIN_MAX) ? GAIN_MAX : hwdata[23:16];
                    analog_ch2_gain <= (hwdata[31:24] > GAIN_MAX) ? GAIN_MAX : hwdata[31:24];
                end
                ADDR_ANALOG_BIAS:
                begin
                    analog_ch1_bias <= ($signed(hwdata[8:0]) > BIAS_MAX) ? BIAS_MAX :
                        ($signed(hwdata[8:0]) < BIAS_MIN) ? BIAS_MIN : $signed(hwdata[8:0]);
                    analog_ch2_bias <= ($signed(hwdata[24:16]) > BIAS_MAX) ? BIAS_MAX :
                        ($signed(hwdata[24:16]) < BIAS_MIN) ? BIAS_MIN : $signed(hwdata[24:16]);
                end
                ADDR_RELAY_CFG:
                begin
                    relay_ch1_source <= hwdata[5:0];
                    relay_ch2_source <= hwdata[13:8];
                end
                ADDR_MODE_CFG:
                begin
                    eight_line_output_mode <= hwdata[0];
                    pulse_monitor_multiplier <= (hwdata[5:3] > 3'h4) ? 3'h4 : hwdata[5:3];
                    comm_loss_stop_method <= domo_stop_t'(hwdata[7:6]);
                end
                ADDR_IRQ_MASK: irq_mask <= hwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status: write one clears, a new event wins over the clear
    always_comb
    begin
        next_irq_status = irq_status;
        if (wr_pend && wr_addr == ADDR_IRQ_STATUS)
            next_irq_status = irq_status & ~hwdata[IRQ_W-1:0];
        next_irq_status = next_irq_status | irq_events;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_status <= '0;
        else
            irq_status <= next_irq_status;
    end
    assign irq = |(irq_status & irq_mask);

    // Analog channels; unused source codes read as zero volts
    logic signed [11:0] sel1, sel2;
    always_comb
    begin
        sel1 = $signed(mon_levels[analog_ch1_source_select[4:0]]);
        sel2 = $signed(mon_levels[analog_ch2_source_select[4:0]]);
        if (analog_ch1_source_select[5])
            sel1 = 12'sh000;
        if (analog_ch2_source_select[5])
            sel2 = 12'sh000;
    end

    domo_analog_ch u_ch1 (
        .hclk(hclk),
        .hresetn(hresetn),
        .gain(analog_ch1_gain),
        .bias(analog_ch1_bias),
        .level_in(sel1),
        .level_out(analog_ch1)
    );

    domo_analog_ch u_ch2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .gain(analog_ch2_gain),
        .bias(analog_ch2_bias),
        .level_in(sel2),
        .level_out(analog_ch2)
    );

    // Relay decode; unsupported codes stay open
    function automatic logic relay_decode(input logic [5:0] code, input domo_status_t s);
        unique case (code)
            RLY_RUN1, RLY_RUN2: relay_decode = s.running;
            RLY_ZERO: relay_decode = s.zero_speed;
            RLY_READY: relay_decode = s.ready;
            RLY_UV: relay_decode = s.undervoltage;
            RLY_FAULT: relay_decode = s.fault;
            RLY_MINOR: relay_decode = s.minor_fault;
            RLY_REV: relay_decode = s.reverse;
            RLY_REGEN: relay_decode = s.regenerating;
            RLY_LIMIT: relay_decode = s.limit;
            default: relay_decode = 1'b0;
        endcase
    endfunction

    // Fault code by priority of table order
    logic [3:0] fault_code;
    always_comb
    begin
        fault_code = FC_NONE;
        if (faults.overcurrent) fault_code = FC_OC;
        else if (faults.overvoltage) fault_code = FC_OV;
        else if (faults.drive_overload_fault) fault_code = FC_DRV_OL;
        else if (faults.overheat) fault_code = FC_OH;
        else if (faults.overspeed) fault_code = FC_OS;
        else if (faults.fuse_fault) fault_code = FC_FUSE;
        else if (faults.external) fault_code = FC_EXT;
        else if (faults.controller) fault_code = FC_CTRL;
        else if (faults.motor_overload_fault) fault_code = FC_MOT_OL;
        else if (faults.power_loss) fault_code = FC_PWR;
        else if (faults.speed_deviation_fault) fault_code = FC_DEV;
        else if (faults.encoder_loss_fault) fault_code = FC_ENC;
    end

    // Terminal map: bit 0..3, 5 = fault lines, 4 = open, 6 = TD1/2, 7 = TD3/4 in normal mode; eight-line mode puts the fault code in bit 0..3; 1 = closed
    logic [7:0] next_term_out;
    logic [1:0] next_relay_out;
    always_comb
    begin
        next_relay_out = {relay_decode(relay_ch2_source, status),
            relay_decode(relay_ch1_source, status)};
        if (!eight_line_output_mode)
            next_term_out = {status.speed_agree, status.zero_speed, faults.overheat, 1'b0,
                faults.fuse_fault, faults.drive_overload_fault, faults.overvoltage,
                faults.overcurrent};
        else
            next_term_out = {status.minor_fault, status.running, status.speed_agree,
                status.zero_speed, fault_code};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            term_out <= 8'h00;
            relay_out <= 2'b00;
        end
        else
        begin
            term_out <= next_term_out;
            relay_out <= next_relay_out;
        end
    end

    // Pulse monitor: accumulator toggles output on carry
    logic [PHASE_W-1:0] phase, next_phase, step;
    logic [PHASE_W:0] phase_sum;
    logic next_pulse_out;
    always_comb
    begin
        unique case (pulse_monitor_multiplier)
            3'h0: step = out_freq_step;
            3'h1: step = PHASE_W'(out_freq_step * 6);
            3'h2: step = PHASE_W'(out_freq_step * 10);
            3'h3: step = PHASE_W'(out_freq_step * 12);
            default: step = PHASE_W'(out_freq_step * 36);
        endcase
        phase_sum = {1'b0, phase} + {1'b0, step};
        next_phase = phase_sum[PHASE_W-1:0];
        next_pulse_out = phase_sum[PHASE_W] ? ~pulse_out : pulse_out;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= '0;
            pulse_out <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            pulse_out <= next_pulse_out;
        end
    end

    // Comm link watch: no fault before first good link
    domo_link_t link_state, next_link_state;
    logic next_loss_event;
    always_comb
    begin
        next_link_state = link_state;
        next_loss_event = 1'b0;
        unique case (link_state)
            LINK_WAIT: if (link_ok) next_link_state = LINK_UP;
            LINK_UP:
                if (!link_ok)
                begin
                    next_link_state = LINK_LOST;
                    next_loss_event = 1'b1;
                end
            LINK_LOST: if (link_ok) next_link_state = LINK_UP;
            default: next_link_state = LINK_WAIT;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            link_state <= LINK_WAIT;
        else
            link_state <= next_link_state;
    end

    assign comm_loss_fault = (link_state == LINK_LOST);
    assign comm_stop_action = comm_loss_stop_method;
    assign comm_alarm = comm_loss_fault && (comm_loss_stop_method == STOP_ALARM_RUN);
    assign irq_events = {status.minor_fault, status.fault, next_loss_event};
endmodule

// ===== domo_monitor_checker.sv
`timescale 1ns/1ps
module domo_monitor_checker
    import domo_pkg::*;
(
    // Bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Drive side
    input wire domo_status_t status,
    input wire domo_faults_t faults,
    input wire logic [31:0] out_freq_step,
    input wire logic link_ok,
    input wire logic signed [11:0] analog_ch1,
    input wire logic signed [11:0] analog_ch2,
    input wire logic [7:0] term_out,
    input wire logic pulse_out,
    input wire logic comm_loss_fault
);
    logic seen_up;
    logic next_seen_up;
    logic rd_take;

    // Link history; a loss is only legal once the link came up
    assign next_seen_up = seen_up | link_ok;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;

    // History register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            seen_up <= 1'b0;
        else
            seen_up <= next_seen_up;
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_BUS_READY: assert property (hreadyout)
        else $error("slave inserted a wait state");
    AST_BUS_OKAY: assert property (!hresp)
        else $error("slave gave an error response");
    AST_CH1_RANGE: assert property (analog_ch1 <= LEVEL_FULL && analog_ch1 >= -LEVEL_FULL)
        else $error("channel 1 level beyond full scale");
    AST_CH2_RANGE: assert property (analog_ch2 <= LEVEL_FULL && analog_ch2 >= -LEVEL_FULL)
        else $error("channel 2 level beyond full scale");
    AST_NO_LOSS_EARLY: assert property (!seen_up |-> !comm_loss_fault)
        else $error("link loss flagged before first link");
    AST_LOSS_CLEARS: assert property (link_ok |=> !comm_loss_fault)
        else $error("link loss flag stayed with link good");
    AST_PULSE_STILL: assert property ((out_freq_step == 32'h0)[*4] |=> $stable(pulse_out))
        else $error("pulse moved at zero frequency");
    AST_UNMAPPED_ZERO: assert property (rd_take && haddr[31:8] == 24'h0 && haddr[7:0] >= 8'h20
        |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_TERM_CLEAR: assert property ((faults == '0)[*2] |=> term_out[3:0] == 4'h0)
        else $error("fault terminals closed with no fault");
    AST_TERM_BIT4: assert property ((!status.zero_speed)[*2] |=> !term_out[4])
        else $error("terminal 4 closed without zero speed");
endmodule

bind domo_monitor domo_monitor_checker i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .status, .faults, .out_freq_step, .link_ok,
    .analog_ch1, .analog_ch2, .term_out, .pulse_out, .comm_loss_fault);

// ===== domo_monitor_tb.sv
`timescale 1ns/1ps
module domo_monitor_tb
    import domo_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, link_en, link_ok, cnt_clr;
    logic [31:0] haddr, hwdata, hrdata, out_freq_step, q;
    logic [1:0] htrans, relay_out;
    logic [2:0] hsize;
    logic [7:0] term_out;
    logic [11:0] mon_levels [0:31];
    logic signed [11:0] analog_ch1, analog_ch2;
    logic pulse_out, comm_loss_fault, comm_alarm, irq;
    logic [15:0] edge_cnt;
    domo_status_t status;
    domo_faults_t faults;
    domo_stop_t comm_stop_action;
    int err_total, total_checks, cyc;
    logic [5:0] rcode [10] = '{RLY_RUN1, RLY_ZERO, RLY_READY, RLY_UV, RLY_FAULT, RLY_MINOR,
        RLY_REV, RLY_REGEN, RLY_LIMIT, RLY_RUN2};
    int rbit [10] = '{9, 8, 7, 6, 5, 4, 3, 2, 1, 9};
    logic [3:0] fcode [12] = '{FC_OC, FC_OV, FC_DRV_OL, FC_OH, FC_OS, FC_FUSE, FC_EXT,
        FC_CTRL, FC_MOT_OL, FC_PWR, FC_DEV, FC_ENC};
    logic [7:0] fterm [12] = '{8'h01, 8'h02, 8'h04, 8'h20, 8'h00, 8'h08, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00};
    int mult [5] = '{1, 6, 10, 12, 36};

    domo_monitor i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .status, .faults, .mon_levels,
        .out_freq_step, .link_ok, .analog_ch1, .analog_ch2, .relay_out, .term_out,
        .pulse_out, .comm_loss_fault, .comm_stop_action, .comm_alarm, .irq);
    domo_partner i_far (.hclk, .hresetn, .link_en, .cnt_clr, .pulse_out, .link_ok, .edge_cnt);

    // Clock
    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic print_verdict;
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, well above the pulse counting time
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Counts may slip by up to two edges at the window borders
    task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if ($isunknown(got) || got + 16'h2 < exp || got > exp + 16'h2)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // One single AHB-Lite word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // Read data taken at the edge that ends the data phase
        q = hrdata;
    endtask

    task automatic t_reset;
        bus(0, ADDR_ANALOG_CFG, 0);
        chk(q, {GAIN2_RESET, GAIN1_RESET, 2'b0, SRC2_RESET, 2'b0, SRC1_RESET});
        bus(0, ADDR_ANALOG_BIAS, 0);
        chk(q, {7'h0, BIAS_RESET, 7'h0, BIAS_RESET});
        bus(0, ADDR_RELAY_CFG, 0);
        chk(q, {18'h0, RLY2_RESET, 2'b0, RLY1_RESET});
        bus(0, ADDR_MODE_CFG, 0);
        chk(q, {24'h0, 2'b01, PULSE_SEL_RESET, 3'h0});
        bus(0, 8'h24, 0);
        chk(q, 32'h0);
    endtask

    task automatic t_analog;
        mon_levels[0] <= 12'h100;
        mon_levels[3] <= 12'h200;
        bus(1, ADDR_ANALOG_CFG, {GAIN2_RESET, 8'hfa, 2'b0, SRC2_RESET, 2'b0, SRC1_RESET});
        bus(1, ADDR_ANALOG_BIAS, {7'h0, 9'h1fe, 7'h0, 9'h005});
        tick(3);
        chk({20'h0, analog_ch1}, 32'h2b2);
        chk({20'h0, analog_ch2}, 32'h0ec);
        mon_levels[0] <= 12'h3ff;
        bus(1, ADDR_ANALOG_CFG, {GAIN2_RESET, 8'hff, 2'b0, SRC2_RESET, 2'b0, SRC1_RESET});
        bus(0, ADDR_ANALOG_CFG, 0);
        chk({24'h0, q[23:16]}, {24'h0, GAIN_MAX});
        tick(3);
        chk({20'h0, analog_ch1}, 32'h3ff);
        bus(1, ADDR_ANALOG_BIAS, {7'h0, 9'h1fe, 7'h0, 9'h0c8});
        bus(0, ADDR_ANALOG_BIAS, 0);
        chk({23'h0, q[8:0]}, {23'h0, BIAS_MAX});
        bus(1, ADDR_ANALOG_CFG, {GAIN2_RESET, 8'h00, 2'b0, SRC2_RESET, 2'b0, SRC1_RESET});
        bus(1, ADDR_ANALOG_BIAS, {7'h0, 9'h1fe, 7'h0, 9'h19c});
        tick(3);
        chk({20'h0, analog_ch1}, 32'hc18);
        bus(0, ADDR_LEVELS, 0);
        chk(q, 32'h00ec_0c18);
    endtask

    task automatic t_relay;
        for (int i = 0; i < 10; i++)
        begin
            bus(1, ADDR_RELAY_CFG, {18'h0, rcode[9 - i], 2'b0, rcode[i]});
            status <= domo_status_t'(10'h1 << rbit[i]);
            tick(3);
            chk({30'h0, relay_out}, {30'h0, rbit[9 - i] == rbit[i], 1'b1});
            status <= '0;
            tick(3);
            chk({30'h0, relay_out}, 32'h0);
        end
    endtask

    task automatic t_term;
        for (int m = 0; m < 2; m++)
        begin
            bus(1, ADDR_MODE_CFG, {24'h0, 2'b01, 3'h1, 2'b0, m[0]});
            for (int i = 0; i < 12; i++)
            begin
                faults <= domo_faults_t'(12'h800 >> i);
                tick(3);
                chk({24'h0, term_out}, {24'h0, m ? {4'h0, fcode[i]} : fterm[i]});
            end
            faults <= '0;
            status <= domo_status_t'(10'h311);
            tick(3);
            chk({24'h0, term_out}, m ? 32'hf0 : 32'hc0);
            status <= '0;
        end
        faults <= domo_faults_t'(12'h401);
        tick(3);
        chk({24'h0, term_out}, {28'h0, FC_OV});
        faults <= '0;
    endtask

    task automatic t_pulse;
        out_freq_step <= 32'h0100_0000;
        for (int s = 0; s < 5; s++)
        begin
            bus(1, ADDR_MODE_CFG, {24'h0, 2'b01, s[2:0], 3'h0});
            tick(8);
            cnt_clr <= 1'b1;
            tick(1);
            cnt_clr <= 1'b0;
            tick(2560);
            chk_cnt(edge_cnt, 16'(mult[s] * 10));
        end
        out_freq_step <= 32'h0;
        bus(1, ADDR_MODE_CFG, {24'h0, 2'b01, 3'h7, 3'h0});
        bus(0, ADDR_MODE_CFG, 0);
        chk({29'h0, q[5:3]}, 32'h4);
    endtask

    task automatic t_comm;
        // Earlier scenarios left fault and minor events sticky
        bus(1, ADDR_IRQ_STATUS, 32'h7);
        tick(20);
        chk({31'h0, comm_loss_fault}, 32'h0);
        link_en <= 1'b1;
        tick(4);
        link_en <= 1'b0;
        tick(4);
        chk({31'h0, comm_loss_fault}, 32'h1);
        bus(0, ADDR_IRQ_STATUS, 0);
        chk(q, 32'h1);
        bus(1, ADDR_IRQ_MASK, 32'h7);
        tick(2);
        chk({31'h0, irq}, 32'h1);
        bus(1, ADDR_IRQ_MASK, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            bus(1, ADDR_MODE_CFG, {24'h0, m[1:0], 3'h1, 3'h0});
            tick(3);
            chk({30'h0, comm_stop_action}, m);
            chk({31'h0, comm_alarm}, {31'h0, m == 3});
        end
        link_en <= 1'b1;
        tick(4);
        chk({31'h0, comm_loss_fault}, 32'h0);
        bus(1, ADDR_IRQ_STATUS, 32'h1);
        bus(0, ADDR_IRQ_STATUS, 0);
        chk(q, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        status = '0;
        faults = '0;
        out_freq_step = 32'h0;
        link_en = 1'b0;
        cnt_clr = 1'b0;
        err_total = 0;
        total_checks = 0;
        cyc = 0;
        for (int i = 0; i < 32; i++)
            mon_levels[i] = 12'h0;
        tick(4);
        hresetn <= 1'b1;
        tick(1);
        t_reset();
        t_analog();
        t_relay();
        t_term();
        t_pulse();
        t_comm();
        print_verdict();
    end
endmodule

// ===== domo_partner.sv
`timescale 1ns/1ps
module domo_partner
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Controller side
    input wire logic link_en,
    input wire logic cnt_clr,
    input wire logic pulse_out,
    output logic link_ok,
    output logic [15:0] edge_cnt
);
    logic last_pulse;

    // Link follows the controller; counter sees every pulse edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            link_ok <= 1'b0;
            last_pulse <= 1'b0;
            edge_cnt <= 16'h0;
        end
        else
        begin
            link_ok <= link_en;
            last_pulse <= pulse_out;
            edge_cnt <= cnt_clr ? 16'h0 : edge_cnt + {15'h0, pulse_out ^ last_pulse};
        end
    end
endmodule

// ===== domo_pkg.sv
package domo_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_ANALOG_CFG = 8'h00;
    localparam logic [7:0] ADDR_ANALOG_BIAS = 8'h04;
    localparam logic [7:0] ADDR_RELAY_CFG = 8'h08;
    localparam logic [7:0] ADDR_MODE_CFG = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_LEVELS = 8'h18;
    localparam logic [7:0] ADDR_OUTPUTS = 8'h1c;

    // Gain in hundredths, bias in tenths of a volt
    localparam logic [7:0] GAIN1_RESET = 8'h64;
    localparam logic [7:0] GAIN2_RESET = 8'h32;
    localparam logic [7:0] GAIN_MAX = 8'hfa;
    localparam logic signed [8:0] BIAS_RESET = 9'sh000;
    localparam logic signed [8:0] BIAS_MAX = 9'sh064;
    localparam logic signed [8:0] BIAS_MIN = -9'sh064;
    localparam logic [5:0] SRC1_RESET = 6'h00;
    localparam logic [5:0] SRC2_RESET = 6'h03;

    // Monitor levels: full scale 0x3ff means 10 V
    localparam logic signed [11:0] LEVEL_FULL = 12'sh3ff;
    localparam logic signed [11:0] LEVEL_PER_TENTH = 12'sh00a;

    // Relay source codes
    localparam logic [5:0] RLY_RUN1 = 6'h00;
    localparam logic [5:0] RLY_ZERO = 6'h01;
    localparam logic [5:0] RLY_READY = 6'h06;
    localparam logic [5:0] RLY_UV = 6'h07;
    localparam logic [5:0] RLY_FAULT = 6'h0e;
    localparam logic [5:0] RLY_MINOR = 6'h10;
    localparam logic [5:0] RLY_REV = 6'h1a;
    localparam logic [5:0] RLY_REGEN = 6'h1d;
    localparam logic [5:0] RLY_LIMIT = 6'h30;
    localparam logic [5:0] RLY_RUN2 = 6'h37;
    localparam logic [5:0] RLY1_RESET = 6'h00;
    localparam logic [5:0] RLY2_RESET = 6'h01;

    // Fault code encodings
    localparam logic [3:0] FC_NONE = 4'h0;
    localparam logic [3:0] FC_OC = 4'h1;
    localparam logic [3:0] FC_OV = 4'h2;
    localparam logic [3:0] FC_DRV_OL = 4'h3;
    localparam logic [3:0] FC_OH = 4'h4;
    localparam logic [3:0] FC_OS = 4'h5;
    localparam logic [3:0] FC_FUSE = 4'h6;
    localparam logic [3:0] FC_EXT = 4'h8;
    localparam logic [3:0] FC_CTRL = 4'h9;
    localparam logic [3:0] FC_MOT_OL = 4'ha;
    localparam logic [3:0] FC_PWR = 4'hc;
    localparam logic [3:0] FC_DEV = 4'hd;
    localparam logic [3:0] FC_ENC = 4'he;

    // Pulse multiplier selector and phase accumulator
    localparam logic [2:0] PULSE_SEL_RESET = 3'h1;
    localparam int PHASE_W = 32;

    // Interrupt bit positions
    localparam int IRQ_COMM_LOSS = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_MINOR = 2;
    localparam int IRQ_W = 3;

    typedef enum logic [1:0]
    {
        STOP_RAMP_FIRST = 2'b00,
        STOP_COAST = 2'b01,
        STOP_RAMP_ALT = 2'b10,
        STOP_ALARM_RUN = 2'b11
    } domo_stop_t;

    typedef enum logic [1:0]
    {
        LINK_WAIT = 2'b00,
        LINK_UP = 2'b01,
        LINK_LOST = 2'b10
    } domo_link_t;

    // Drive status from the control core
    typedef struct packed
    {
        logic running;
        logic zero_speed;
        logic ready;
        logic undervoltage;
        logic fault;
        logic minor_fault;
        logic reverse;
        logic regenerating;
        logic limit;
        logic speed_agree;
    } domo_status_t;

    // Individual fault flags
    typedef struct packed
    {
        logic overcurrent;
        logic overvoltage;
        logic drive_overload_fault;
        logic overheat;
        logic overspeed;
        logic fuse_fault;
        logic external;
        logic controller;
        logic motor_overload_fault;
        logic power_loss;
        logic speed_deviation_fault;
        logic encoder_loss_fault;
    } domo_faults_t;

endpackage
